/* File: design/dacld_host.v */
// host controller driving byte-wide and word-wide double-buffered dacs
`timescale 1ns/1ns
`include "dacld_regs.vh"
module dacld_host (
  input wire clk_sys,
  input wire rst,
  input wire cmd_valid,
  input wire [1:0] cmd_op,
  input wire [1:0] cmd_chan,
  input wire [13:0] cmd_data,
  output reg cmd_ready_r,
  output reg cmd_done_r,
  output reg [7:0] byte_data_r,
  output reg reg_select_bit0_r,
  output reg reg_select_bit1_r,
  output reg byte_cs_n_r,
  output reg byte_wr_n_r,
  output reg [13:0] parallel_data_in_r,
  output reg [3:0] high_byte_select_n_r,
  output reg [3:0] low_byte_select_n_r,
  output reg word_wr_n_r,
  output reg dac_update_strobe_n_r
);
  // command codes
  localparam OP_BYTE = 2'h0;
  localparam OP_WLOAD = 2'h1;
  localparam OP_UPDATE = 2'h2;
  localparam OP_BYPASS = 2'h3;
  // sequencer states
  localparam ST_IDLE = 3'h0;
  localparam ST_HIGH = 3'h1;
  localparam ST_LOW = 3'h2;
  localparam ST_XFER = 3'h3;
  localparam ST_WORD = 3'h4;
  localparam ST_UPD = 3'h5;
  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg [1:0] op_r;
  reg [1:0] chan_r;
  reg [13:0] word_r;
  reg go_r;
  wire str_active;
  wire str_busy;
  wire str_done;
  wire [3:0] chan_hit;
  // one strobe engine shared by every write cycle
  dacld_strobe u_strobe (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(go_r),
    .active_r(str_active),
    .busy_r(str_busy),
    .done_r(str_done)
  );
  // per-channel select decode for the word-wide converters
  genvar gi;
  generate
    for (gi = 0; gi < `DACLD_CHAN_N; gi = gi + 1) begin : g_chan
      assign chan_hit[gi] = (chan_r == gi);
    end
  endgenerate
  // next state of the write sequencer
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        // a command is taken only while ready stands high
        if (cmd_valid && cmd_ready_r) begin
          case (cmd_op)
            OP_BYTE: st_nxt = ST_HIGH;
            OP_WLOAD: st_nxt = ST_WORD;
            OP_BYPASS: st_nxt = ST_WORD;
            default: st_nxt = ST_UPD;
          endcase
        end
      end
      ST_HIGH: begin
        if (str_done) begin
          st_nxt = ST_LOW;
        end
      end
      ST_LOW: begin
        if (str_done) begin
          st_nxt = ST_XFER;
        end
      end
      ST_XFER: begin
        if (str_done) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_WORD: begin
        if (str_done) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_UPD: begin
        if (str_done) begin
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end
  // sequencer state and strobe kick
  always @(posedge clk_sys) begin
    if (rst) begin
      st_r <= ST_IDLE;
      go_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      // a write starts on acceptance or as soon as the previous one ends
      go_r <= (st_nxt != ST_IDLE) && ((st_r == ST_IDLE) || str_done);
    end
  end
  // handshake towards the command source
  always @(posedge clk_sys) begin
    if (rst) begin
      cmd_ready_r <= 1'b0;
      cmd_done_r <= 1'b0;
    end else begin
      // ready drops on acceptance so one command is taken at a time
      cmd_ready_r <= (st_nxt == ST_IDLE) && !(cmd_valid && cmd_ready_r);
      cmd_done_r <= str_done && (st_nxt == ST_IDLE);
    end
  end
  // command capture, held until the command ends
  always @(posedge clk_sys) begin
    if (rst) begin
      op_r <= OP_BYTE;
      chan_r <= 2'h0;
      word_r <= 14'h0000;
    end else if (cmd_valid && cmd_ready_r) begin
      op_r <= cmd_op;
      chan_r <= cmd_chan;
      word_r <= cmd_data;
    end
  end
  // byte bus: code and data settle while chip select is still high
  always @(posedge clk_sys) begin
    if (rst) begin
      byte_data_r <= 8'h00;
      reg_select_bit0_r <= 1'b0;
      reg_select_bit1_r <= 1'b0;
      byte_cs_n_r <= 1'b1;
      byte_wr_n_r <= 1'b1;
    end else begin
      byte_cs_n_r <= 1'b1;
      byte_wr_n_r <= 1'b1;
      case (st_r)
        ST_HIGH: begin
          // only low six lines carry data for the high byte
          byte_data_r <= {2'h0, word_r[13:8]};
          {reg_select_bit1_r, reg_select_bit0_r} <= `DACLD_SEL_HIGH;
          byte_cs_n_r <= !str_busy;
          byte_wr_n_r <= !str_active;
        end
        ST_LOW: begin
          byte_data_r <= word_r[7:0];
          {reg_select_bit1_r, reg_select_bit0_r} <= `DACLD_SEL_LOW;
          byte_cs_n_r <= !str_busy;
          byte_wr_n_r <= !str_active;
        end
        ST_XFER: begin
          // data lines keep the low byte; converter ignores them
          {reg_select_bit1_r, reg_select_bit0_r} <= `DACLD_SEL_XFER;
          byte_cs_n_r <= !str_busy;
          byte_wr_n_r <= !str_active;
        end
        default: begin
          {reg_select_bit1_r, reg_select_bit0_r} <= `DACLD_SEL_IDLE;
        end
      endcase
    end
  end
  // word bus: data and selects stand for the whole write cycle
  always @(posedge clk_sys) begin
    if (rst) begin
      parallel_data_in_r <= 14'h0000;
      high_byte_select_n_r <= 4'hF;
      low_byte_select_n_r <= 4'hF;
      word_wr_n_r <= 1'b1;
    end else begin
      case (st_r)
        ST_WORD: begin
          parallel_data_in_r <= word_r;
          high_byte_select_n_r <= ~chan_hit;
          low_byte_select_n_r <= ~chan_hit;
          word_wr_n_r <= !str_active;
        end
        default: begin
          // deselected: data lines keep the last word
          high_byte_select_n_r <= 4'hF;
          low_byte_select_n_r <= 4'hF;
          word_wr_n_r <= 1'b1;
        end
      endcase
    end
  end
  // shared update strobe: pulse for a transfer, whole write cycle for bypass
  always @(posedge clk_sys) begin
    if (rst) begin
      dac_update_strobe_n_r <= 1'b1;
    end else begin
      case (st_r)
        ST_WORD: begin
          // bypass: all low makes every register transparent, released on the edge that raises cmd_done_r
          dac_update_strobe_n_r <= !((op_r == OP_BYPASS) && str_busy);
        end
        ST_UPD: begin
          // shared update pulse reaches every word-wide converter at once
          dac_update_strobe_n_r <= !str_active;
        end
        default: begin
          dac_update_strobe_n_r <= 1'b1;
        end
      endcase
    end
  end
endmodule

/* File: design/dacld_regs.vh */
// constants for the dac double-buffer loader host controller
`ifndef DACLD_REGS_VH
`define DACLD_REGS_VH
`define DACLD_DATA_W 14
`define DACLD_HIGH_W 6
`define DACLD_CHAN_N 4
`define DACLD_CHAN_W 2
`define DACLD_SEL_HIGH 2'h1
`define DACLD_SEL_LOW 2'h2
`define DACLD_SEL_XFER 2'h3
`define DACLD_SEL_IDLE 2'h0
`define DACLD_SETUP_NS 20
`define DACLD_STROBE_NS 60
`define DACLD_HOLD_NS 20
`define DACLD_CLK_NS 4
`define DACLD_SETUP_CYC ((`DACLD_SETUP_NS + `DACLD_CLK_NS - 1) / `DACLD_CLK_NS)
`define DACLD_STROBE_CYC ((`DACLD_STROBE_NS + `DACLD_CLK_NS - 1) / `DACLD_CLK_NS)
`define DACLD_HOLD_CYC ((`DACLD_HOLD_NS + `DACLD_CLK_NS - 1) / `DACLD_CLK_NS)
`endif

/* File: design/dacld_strobe.v */
// timed strobe generator: setup, active, hold phases
`timescale 1ns/1ns
`include "dacld_regs.vh"
module dacld_strobe (
  input wire clk_sys,
  input wire rst,
  input wire start,
  output reg active_r,
  output reg busy_r,
  output reg done_r
);
  localparam PH_IDLE = 2'h0;
  localparam PH_SETUP = 2'h1;
  localparam PH_ACT = 2'h2;
  localparam PH_HOLD = 2'h3;
  localparam integer SETUP_I = `DACLD_SETUP_CYC;
  localparam integer STROBE_I = `DACLD_STROBE_CYC;
  localparam integer HOLD_I = `DACLD_HOLD_CYC;
  // counts cut to the counter width on purpose
  localparam [4:0] SETUP_C = SETUP_I[4:0];
  localparam [4:0] STROBE_C = STROBE_I[4:0];
  localparam [4:0] HOLD_C = HOLD_I[4:0];
  reg [1:0] ph_r;
  reg [4:0] cnt_r;
  // phase sequencer, each phase lasts its cycle count
  always @(posedge clk_sys) begin
    if (rst) begin
      ph_r <= PH_IDLE;
      cnt_r <= 5'h00;
      active_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (ph_r)
        PH_IDLE: begin
          if (start) begin
            ph_r <= PH_SETUP;
            cnt_r <= SETUP_C - 5'h01;
            busy_r <= 1'b1;
          end
        end
        PH_SETUP: begin
          if (cnt_r == 5'h00) begin
            ph_r <= PH_ACT;
            cnt_r <= STROBE_C - 5'h01;
            active_r <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        PH_ACT: begin
          if (cnt_r == 5'h00) begin
            ph_r <= PH_HOLD;
            cnt_r <= HOLD_C - 5'h01;
            active_r <= 1'b0;
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        PH_HOLD: begin
          if (cnt_r == 5'h00) begin
            ph_r <= PH_IDLE;
            busy_r <= 1'b0;
            done_r <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        default: begin
          ph_r <= PH_IDLE;
        end
      endcase
    end
  end
endmodule

/* File: testbench/dacld_host_asserts.sv */
// pin timing checks for the host
`timescale 1ns/1ns
module dacld_host_chk (
  input wire clk_sys,
  input wire rst,
  input wire cmd_done_r,
  input wire [7:0] byte_data_r,
  input wire reg_select_bit0_r,
  input wire reg_select_bit1_r,
  input wire byte_cs_n_r,
  input wire byte_wr_n_r,
  input wire [3:0] high_byte_select_n_r,
  input wire [3:0] low_byte_select_n_r,
  input wire word_wr_n_r,
  input wire dac_update_strobe_n_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire [1:0] sel = {reg_select_bit1_r, reg_select_bit0_r};
  // byte write phases
  sequence s_setup; byte_wr_n_r [*5] ##1 !byte_wr_n_r; endsequence
  sequence s_strobe; !byte_wr_n_r ##14 !byte_wr_n_r ##1 byte_wr_n_r; endsequence
  sequence s_hold; !byte_cs_n_r [*5] ##1 byte_cs_n_r; endsequence
  a_cs_setup: assert property ($fell(byte_cs_n_r) |-> s_setup) else $error("bad setup");
  a_wr_width: assert property ($fell(byte_wr_n_r) |-> s_strobe) else $error("bad strobe");
  a_cs_hold: assert property ($rose(byte_wr_n_r) && !$past(rst) |-> s_hold)
    else $error("bad hold");
  a_pins_steady: assert property (!byte_cs_n_r && !$past(byte_cs_n_r)
    |-> $stable({sel, byte_data_r})) else $error("pins moved");
  a_high_six: assert property (!byte_cs_n_r && sel == 2'h1
    |-> byte_data_r[7:6] == 2'h0) else $error("high byte wide");
  a_sel_used: assert property (!byte_cs_n_r |-> sel != 2'h0) else $error("idle code");
  a_word_sel: assert property (!word_wr_n_r && dac_update_strobe_n_r
    |-> !(&(high_byte_select_n_r & low_byte_select_n_r))) else $error("no select");
  a_done_idle: assert property (cmd_done_r |-> byte_cs_n_r && word_wr_n_r
    && dac_update_strobe_n_r ##1 !cmd_done_r) else $error("done early");
endmodule
bind dacld_host dacld_host_chk u_chk (.clk_sys(clk_sys), .rst(rst), .cmd_done_r(cmd_done_r),
  .byte_data_r(byte_data_r), .reg_select_bit0_r(reg_select_bit0_r),
  .reg_select_bit1_r(reg_select_bit1_r), .byte_cs_n_r(byte_cs_n_r), .byte_wr_n_r(byte_wr_n_r),
  .high_byte_select_n_r(high_byte_select_n_r), .low_byte_select_n_r(low_byte_select_n_r),
  .word_wr_n_r(word_wr_n_r), .dac_update_strobe_n_r(dac_update_strobe_n_r));

/* File: testbench/dacld_dev_model.sv */
// behavioural byte-wide and word-wide converters
`timescale 1ns/1ns
module dacld_dev_model (
  input wire clk_sys,
  input wire [7:0] byte_data_r,
  input wire reg_select_bit0_r,
  input wire reg_select_bit1_r,
  input wire byte_cs_n_r,
  input wire byte_wr_n_r,
  input wire [13:0] parallel_data_in_r,
  input wire [3:0] high_byte_select_n_r,
  input wire [3:0] low_byte_select_n_r,
  input wire word_wr_n_r,
  input wire dac_update_strobe_n_r,
  output logic [13:0] bdac,
  output logic [13:0] wdac [4]
);
  logic [5:0] bhi, whi [4];
  logic [7:0] blo, wlo [4];
  wire upd = !dac_update_strobe_n_r;
  wire wr = !word_wr_n_r;
  wire [13:0] d = parallel_data_in_r;
  // byte device latches at the end of its write
  always @(posedge byte_wr_n_r) if (!byte_cs_n_r) begin
    case ({reg_select_bit1_r, reg_select_bit0_r})
      2'h1: bhi <= byte_data_r[5:0];
      2'h2: blo <= byte_data_r;
      2'h3: bdac <= {bhi, blo};
      default: ;
    endcase
  end
  // word devices, pins stand many cycles
  always @(posedge clk_sys) begin
    for (int i = 0; i < 4; i++) begin
      if (!upd && wr) begin
        if (!high_byte_select_n_r[i]) whi[i] <= d[13:8];
        if (!low_byte_select_n_r[i]) wlo[i] <= d[7:0];
      end else if (upd && high_byte_select_n_r[i] && low_byte_select_n_r[i]) begin
        wdac[i] <= {whi[i], wlo[i]};
      end else if (upd && wr && !high_byte_select_n_r[i] && !low_byte_select_n_r[i]) begin
        {whi[i], wlo[i]} <= d;
        wdac[i] <= d;
      end
    end
  end
endmodule

/* File: testbench/dacld_host_test.sv */
// self-checking bench for the dac loader host
`timescale 1ns/1ns
module dacld_host_test;
  logic clk_sys = 0, rst = 1, cmd_valid = 0;
  logic [1:0] cmd_op = 0, cmd_chan = 0;
  logic [13:0] cmd_data = 0, bdac, wdac [4];
  wire cmd_ready_r, cmd_done_r, reg_select_bit0_r, reg_select_bit1_r, byte_cs_n_r;
  wire byte_wr_n_r, word_wr_n_r, dac_update_strobe_n_r;
  wire [7:0] byte_data_r;
  wire [13:0] parallel_data_in_r;
  wire [3:0] high_byte_select_n_r, low_byte_select_n_r;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  // op and channel, data, watched dac (4 is byte-wide), expected
  logic [34:0] rows [8] = '{{4'h0, 14'h3ABC, 3'h4, 14'h3ABC}, {4'h0, 14'h0001, 3'h4, 14'h0001},
    {4'hD, 14'h2AAA, 3'h1, 14'h2AAA}, {4'h5, 14'h1555, 3'h1, 14'h2AAA},
    {4'h6, 14'h0F0F, 3'h1, 14'h2AAA}, {4'h8, 14'h3333, 3'h1, 14'h1555},
    {4'h8, 14'h0000, 3'h2, 14'h0F0F}, {4'hF, 14'h0C0C, 3'h3, 14'h0C0C}};
  dacld_host uut (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_chan(cmd_chan), .cmd_data(cmd_data), .cmd_ready_r(cmd_ready_r),
    .cmd_done_r(cmd_done_r), .byte_data_r(byte_data_r), .reg_select_bit0_r(reg_select_bit0_r),
    .reg_select_bit1_r(reg_select_bit1_r), .byte_cs_n_r(byte_cs_n_r), .byte_wr_n_r(byte_wr_n_r),
    .parallel_data_in_r(parallel_data_in_r), .high_byte_select_n_r(high_byte_select_n_r),
    .low_byte_select_n_r(low_byte_select_n_r), .word_wr_n_r(word_wr_n_r),
    .dac_update_strobe_n_r(dac_update_strobe_n_r));
  dacld_dev_model dev (.clk_sys(clk_sys), .byte_data_r(byte_data_r),
    .reg_select_bit0_r(reg_select_bit0_r), .reg_select_bit1_r(reg_select_bit1_r),
    .byte_cs_n_r(byte_cs_n_r), .byte_wr_n_r(byte_wr_n_r), .parallel_data_in_r(parallel_data_in_r),
    .high_byte_select_n_r(high_byte_select_n_r), .low_byte_select_n_r(low_byte_select_n_r),
    .word_wr_n_r(word_wr_n_r), .dac_update_strobe_n_r(dac_update_strobe_n_r), .bdac(bdac),
    .wdac(wdac));
  always #2 clk_sys = ~clk_sys;
  // cut a hang short
  always @(posedge clk_sys) if (++cyc == 5000) begin
    error_cnt++;
    results;
  end
  task chk(string nm, logic [13:0] seen, logic [13:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task take(logic [3:0] oc, logic [13:0] d);
    @(negedge clk_sys);
    {cmd_op, cmd_chan} = oc;
    cmd_data = d;
    cmd_valid = 1;
    while (cmd_ready_r !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    cmd_valid = 0;
    cmd_data = ~d;
  endtask
  task run(logic [3:0] oc, logic [13:0] d);
    take(oc, d);
    while (cmd_done_r !== 1'b1) @(negedge clk_sys);
  endtask
  task results;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // table rows, then a reset in mid load
  initial begin
    repeat (20) @(negedge clk_sys);
    rst = 0;
    foreach (rows[i]) begin
      run(rows[i][34:31], rows[i][30:17]);
      chk("dac", rows[i][16] ? bdac : wdac[rows[i][15:14]], rows[i][13:0]);
    end
    take(4'h0, 14'h0123);
    repeat (40) @(negedge clk_sys);
    rst = 1;
    @(negedge clk_sys);
    chk("pins", {10'h0, byte_cs_n_r, byte_wr_n_r, word_wr_n_r, dac_update_strobe_n_r}, 14'hF);
    chk("held dac", bdac, 14'h0001);
    rst = 0;
    run(4'h0, 14'h2C3D);
    chk("new dac", bdac, 14'h2C3D);
    results;
  end
endmodule
